//--- core/agu_pkg.sv
/*
   agu_pkg: constants, register indexes, field positions, reset values and
   types shared by the address generation block.
   assumes: a 16-bit data path and a 32-bit Avalon-MM slave port.
*/
`default_nettype none

package agu_pkg;

   // register indexes, byte address is four times the index
   localparam logic [13:0] IDX_MODE_CTL  = 14'h0046;
   localparam logic [13:0] IDX_X_START   = 14'h0048;
   localparam logic [13:0] IDX_X_END     = 14'h004a;
   localparam logic [13:0] IDX_Y_START   = 14'h004c;
   localparam logic [13:0] IDX_Y_END     = 14'h004e;
   localparam logic [13:0] IDX_HOLD_CNT  = 14'h0052;
   localparam logic [13:0] IDX_LAST_X_EA = 14'h0054;
   localparam logic [13:0] IDX_LAST_Y_EA = 14'h0056;
   localparam logic [13:0] IDX_REV_CTL   = 14'h0900;

   // mode control fields
   localparam int X_SEL_LSB   = 0;
   localparam int Y_SEL_LSB   = 4;
   localparam int REV_SEL_LSB = 8;
   localparam int Y_EN_BIT    = 14;
   localparam int X_EN_BIT    = 15;
   localparam logic [15:0] MODE_CTL_MASK = 16'hcfff;

   // reset values
   localparam logic [15:0] RST_MODE_CTL = 16'h0000;
   localparam logic [15:0] RST_START    = 16'h0000;
   localparam logic [15:0] RST_END      = 16'h0001;
   localparam logic [15:0] RST_HOLD_CNT = 16'h0000;
   localparam logic [15:0] RST_REV_CTL  = 16'h0000;

   // pointer numbers
   localparam logic [3:0] PTR_NONE = 4'hf;
   localparam logic [3:0] PTR_W8   = 4'h8;
   localparam logic [3:0] PTR_W9   = 4'h9;
   localparam logic [3:0] PTR_W10  = 4'ha;
   localparam logic [3:0] PTR_W11  = 4'hb;
   localparam logic [3:0] PTR_DEFAULT_WORKING_REGISTER = 4'h0;

   typedef enum logic [2:0] {
      MODE_DIRECT  = 3'b000,
      MODE_FILE    = 3'b001,
      MODE_IND     = 3'b010,
      MODE_POST    = 3'b011,
      MODE_PRE     = 3'b100,
      MODE_INDEXED = 3'b101,
      MODE_LITOFF  = 3'b110,
      MODE_LITERAL = 3'b111
   } agu_mode_type;

   typedef enum logic [1:0] {
      LIT_5  = 2'b00,
      LIT_8  = 2'b01,
      LIT_16 = 2'b10
   } agu_lit_type;

   typedef struct packed {
      logic [15:0] ea;
      logic [15:0] ptr;
      logic        wb;
      logic        mem;
   } agu_ea_type;

endpackage

`default_nettype wire

//--- core/agu_address_unit.sv
/*
   agu_address_unit: X read, X write and Y address units with circular
   buffer correction, literal handling and the circular/hold registers.
   assumes: decoder and register file present pointer values and modes
   in the request cycle; results appear one clock later.
*/
`default_nettype none

module agu_address_unit
#(
   parameter int FILE_ADDR_W = 13,
   parameter int HOLD_W      = 14
)
(
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   // register bus
   input  wire logic [15:0]           avsAddress,
   input  wire logic                  avsRead,
   input  wire logic                  avsWrite,
   input  wire logic [31:0]           avsWritedata,
   input  wire logic [3:0]            avsByteenable,
   output logic [31:0]                avsReaddata,
   output logic                       avsWaitrequest,
   // x read request
   input  wire logic                  xrReq,
   input  wire agu_pkg::agu_mode_type xrMode,
   input  wire logic                  xrMac,
   input  wire logic                  xrMovFull,
   input  wire logic [3:0]            xrPtrSel,
   input  wire logic [15:0]           xrPtr,
   input  wire logic [15:0]           xrMod,
   input  wire logic [15:0]           xrLit,
   input  wire agu_pkg::agu_lit_type  xrLitWidth,
   // x write request
   input  wire logic                  xwReq,
   input  wire agu_pkg::agu_mode_type xwMode,
   input  wire logic                  xwMovFull,
   input  wire logic [3:0]            xwPtrSel,
   input  wire logic [15:0]           xwPtr,
   input  wire logic [15:0]           xwMod,
   input  wire logic [15:0]           xwLit,
   // shared offset register value
   input  wire logic [15:0]           offsetValue,
   // y read request
   input  wire logic                  yReq,
   input  wire agu_pkg::agu_mode_type yMode,
   input  wire logic [3:0]            yPtrSel,
   input  wire logic [15:0]           yPtr,
   input  wire logic [15:0]           yMod,
   // branch and hold instructions
   input  wire logic                  branchReq,
   input  wire logic [15:0]           branchPc,
   input  wire logic [15:0]           branchLit,
   input  wire logic                  holdLoad,
   input  wire logic [HOLD_W-1:0]     holdLit,
   // results
   output logic                       xrValid,
   output logic [15:0]                xrAddr,
   output logic [15:0]                xrPtrNew,
   output logic                       xrPtrWrite,
   output logic                       xrLitValid,
   output logic [15:0]                xrOperand,
   output logic                       xrImplicitW0,
   output logic                       xwValid,
   output logic [15:0]                xwAddr,
   output logic [15:0]                xwPtrNew,
   output logic                       xwPtrWrite,
   output logic                       yValid,
   output logic [15:0]                yAddr,
   output logic [15:0]                yPtrNew,
   output logic                       yPtrWrite,
   output logic                       macError,
   output logic                       branchValid,
   output logic [15:0]                branchTarget,
   output logic                       holdActive
);
   import agu_pkg::*;

   if (FILE_ADDR_W < 1 || FILE_ADDR_W > 15)
   begin : g_bad_file_w
      $error("FILE_ADDR_W must lie between 1 and 15");
   end
   if (HOLD_W < 1 || HOLD_W > 16)
   begin : g_bad_hold_w
      $error("HOLD_W must lie between 1 and 16");
   end

   // bit above the address covers the full 64 Kbyte, 32K word span
   function automatic logic [15:0] wrapAddr(input logic [15:0] a,
                                            input logic        up,
                                            input logic        on,
                                            input logic [15:0] s,
                                            input logic [15:0] e);
      logic [16:0] len;
      logic        bidir;
      logic [15:0] r;
      len   = {1'b0, e} - {1'b0, s} + 17'h0_0001;
      bidir = ((len & (len - 17'h0_0001)) == 17'h0_0000);
      r     = a;
      if (on && (up || bidir) && a > e)
         r = a - len[15:0];
      else if (on && (!up || bidir) && a < s)
         r = a + len[15:0];
      return r;
   endfunction

   function automatic agu_ea_type unitEa(input agu_mode_type m,
                                         input logic [15:0]  ptr,
                                         input logic [15:0]  off,
                                         input logic [15:0]  md,
                                         input logic [15:0]  lit,
                                         input logic         full,
                                         input logic         on,
                                         input logic [15:0]  s,
                                         input logic [15:0]  e);
      agu_ea_type r;
      logic [15:0] step;
      r    = '{ea: 16'h0000, ptr: ptr, wb: 1'b0, mem: 1'b1};
      step = wrapAddr(16'(ptr + md), !md[15], on, s, e);
      case (m)
         MODE_FILE:
            r.ea = full ? lit : 16'(lit[FILE_ADDR_W-1:0]);
         MODE_IND:
            r.ea = ptr;
         MODE_POST:
         begin
            r.ea  = ptr;
            r.ptr = step;
            r.wb  = 1'b1;
         end
         MODE_PRE:
         begin
            r.ea  = step;
            r.ptr = step;
            r.wb  = 1'b1;
         end
         MODE_INDEXED:
            r.ea = wrapAddr(16'(ptr + off), !off[15], on, s, e);
         MODE_LITOFF:
            r.ea = wrapAddr(16'(ptr + lit), !lit[15], on, s, e);
         default:
            r.mem = 1'b0;
      endcase
      return r;
   endfunction

   // register file
   logic [15:0]       modeCtl;
   logic [15:0]       xStart;
   logic [15:0]       xEnd;
   logic [15:0]       yStart;
   logic [15:0]       yEnd;
   logic [HOLD_W-1:0] holdCount;
   logic [15:0]       revCtl;
   logic [15:0]       lastXEa;
   logic [15:0]       lastYEa;

   // bus decode
   wire logic [13:0] regIndex  = avsAddress[15:2];
   wire logic        busReq    = avsRead || avsWrite;
   wire logic        busCommit = avsWrite && !avsWaitrequest;
   wire logic [15:0] wdat      = avsWritedata[15:0];
   wire logic [15:0] beMask    = {{8{avsByteenable[1]}}, {8{avsByteenable[0]}}};
   wire logic        wrMode    = busCommit && regIndex == IDX_MODE_CTL;
   wire logic        wrXStart  = busCommit && regIndex == IDX_X_START;
   wire logic        wrXEnd    = busCommit && regIndex == IDX_X_END;
   wire logic        wrYStart  = busCommit && regIndex == IDX_Y_START;
   wire logic        wrYEnd    = busCommit && regIndex == IDX_Y_END;
   wire logic        wrHold    = busCommit && regIndex == IDX_HOLD_CNT;
   wire logic        wrRev     = busCommit && regIndex == IDX_REV_CTL;
   wire logic [15:0] holdWide  = 16'(holdCount);
   wire logic [15:0] readMux   =
      (regIndex == IDX_MODE_CTL)  ? modeCtl  :
      (regIndex == IDX_X_START)   ? xStart   :
      (regIndex == IDX_X_END)     ? xEnd     :
      (regIndex == IDX_Y_START)   ? yStart   :
      (regIndex == IDX_Y_END)     ? yEnd     :
      (regIndex == IDX_HOLD_CNT)  ? holdWide :
      (regIndex == IDX_LAST_X_EA) ? lastXEa  :
      (regIndex == IDX_LAST_Y_EA) ? lastYEa  :
      (regIndex == IDX_REV_CTL)   ? revCtl   : 16'h0000;

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] nw,
                                         input logic [15:0] msk);
      return (old & ~msk) | (nw & msk);
   endfunction

   // circular enables
   wire logic [3:0] xSel  = modeCtl[X_SEL_LSB +: 4];
   wire logic [3:0] ySel  = modeCtl[Y_SEL_LSB +: 4];
   wire logic       xOn   = modeCtl[X_EN_BIT] && xSel != PTR_NONE;
   wire logic       yOn   = modeCtl[Y_EN_BIT] && ySel != PTR_NONE;
   wire logic       xrCirc = xOn && xrPtrSel == xSel;
   wire logic       xwCirc = xOn && xwPtrSel == xSel;
   wire logic       yCirc  = yOn && yPtrSel == ySel;

   // unit results; both x units see the same offset register
   wire agu_ea_type xrRes = unitEa(xrMode, xrPtr, offsetValue, xrMod, xrLit,
                                   xrMovFull, xrCirc, xStart, xEnd);
   wire agu_ea_type xwRes = unitEa(xwMode, xwPtr, offsetValue, xwMod, xwLit,
                                   xwMovFull, xwCirc, xStart, xEnd);
   wire agu_ea_type yRes  = unitEa(yMode, yPtr, offsetValue, yMod, 16'h0000,
                                   1'b0, yCirc, yStart, yEnd);

   // MAC checks
   wire logic [15:0] yModAbs = yMod[15] ? 16'(-yMod) : yMod;
   wire logic [15:0] xModAbs = xrMod[15] ? 16'(-xrMod) : xrMod;
   wire logic yModOk = yModAbs == 16'h0002 || yModAbs == 16'h0004 ||
                       yModAbs == 16'h0006;
   wire logic xModOk = xModAbs == 16'h0002 || xModAbs == 16'h0004 ||
                       xModAbs == 16'h0006;
   wire logic yPtrOk = yPtrSel == PTR_W10 || yPtrSel == PTR_W11;
   wire logic xPtrOk = xrPtrSel == PTR_W8 || xrPtrSel == PTR_W9;
   wire logic yOk = yPtrOk && (yMode == MODE_IND ||
                    (yMode == MODE_POST && yModOk) ||
                    (yMode == MODE_INDEXED && yPtrSel == PTR_W11));
   wire logic xMacOk = xPtrOk && (xrMode == MODE_IND ||
                       (xrMode == MODE_POST && xModOk) ||
                       (xrMode == MODE_INDEXED && xrPtrSel == PTR_W9));
   wire logic xrOk = !xrMac || xMacOk;
   wire logic next_macError = (yReq && !yOk) || (xrReq && !xrOk);

   // literal operand widths
   wire logic [15:0] litSized =
      (xrLitWidth == LIT_5) ? {11'h000, xrLit[4:0]} :
      (xrLitWidth == LIT_8) ? {8'h00, xrLit[7:0]}   : xrLit;

   // y is a word unit: address bit zero always clear
   wire logic [15:0] yEaWord  = {yRes.ea[15:1], 1'b0};
   wire logic [15:0] yPtrWord = {yRes.ptr[15:1], 1'b0};

   wire logic [15:0] holdMerged = merge(holdWide, wdat, beMask);

   wire logic [HOLD_W-1:0] next_holdCount =
      holdLoad ? holdLit :
      wrHold   ? holdMerged[HOLD_W-1:0] :
      (holdCount != '0) ? HOLD_W'(holdCount - 1'b1) : holdCount;

   // bus handshake: one wait cycle, then answer
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         avsWaitrequest <= 1'b1;
         avsReaddata    <= 32'h0000_0000;
      end
      else
      begin
         avsWaitrequest <= !(busReq && avsWaitrequest);
         if (avsRead && avsWaitrequest)
            avsReaddata <= {16'h0000, readMux};
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         modeCtl   <= RST_MODE_CTL;
         xStart    <= RST_START;
         xEnd      <= RST_END;
         yStart    <= RST_START;
         yEnd      <= RST_END;
         holdCount <= HOLD_W'(RST_HOLD_CNT);
         revCtl    <= RST_REV_CTL;
      end
      else
      begin
         if (wrMode)
            modeCtl <= merge(modeCtl, wdat, beMask) & MODE_CTL_MASK;
         if (wrXStart)
            xStart <= merge(xStart, wdat, beMask) & 16'hfffe;
         if (wrXEnd)
            xEnd <= merge(xEnd, wdat, beMask) | 16'h0001;
         if (wrYStart)
            yStart <= merge(yStart, wdat, beMask) & 16'hfffe;
         if (wrYEnd)
            yEnd <= merge(yEnd, wdat, beMask) | 16'h0001;
         if (wrRev)
            revCtl <= merge(revCtl, wdat, beMask);
         holdCount <= next_holdCount;
      end
   end

   // address unit results, one clock after the request
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         xrValid      <= 1'b0;
         xrAddr       <= 16'h0000;
         xrPtrNew     <= 16'h0000;
         xrPtrWrite   <= 1'b0;
         xrLitValid   <= 1'b0;
         xrOperand    <= 16'h0000;
         xrImplicitW0 <= 1'b0;
         xwValid      <= 1'b0;
         xwAddr       <= 16'h0000;
         xwPtrNew     <= 16'h0000;
         xwPtrWrite   <= 1'b0;
         yValid       <= 1'b0;
         yAddr        <= 16'h0000;
         yPtrNew      <= 16'h0000;
         yPtrWrite    <= 1'b0;
         macError     <= 1'b0;
         branchValid  <= 1'b0;
         branchTarget <= 16'h0000;
         holdActive   <= 1'b0;
         lastXEa      <= 16'h0000;
         lastYEa      <= 16'h0000;
      end
      else
      begin
         xrValid      <= xrReq && xrOk && xrRes.mem;
         xrAddr       <= xrRes.ea;
         xrPtrNew     <= xrRes.ptr;
         xrPtrWrite   <= xrReq && xrOk && xrRes.wb;
         xrLitValid   <= xrReq && xrMode == MODE_LITERAL;
         xrOperand    <= litSized;
         xrImplicitW0 <= xrReq && xrMode == MODE_FILE;
         xwValid      <= xwReq && xwRes.mem;
         xwAddr       <= xwRes.ea;
         xwPtrNew     <= xwRes.ptr;
         xwPtrWrite   <= xwReq && xwRes.wb;
         yValid       <= yReq && yOk;
         yAddr        <= yEaWord;
         yPtrNew      <= yPtrWord;
         yPtrWrite    <= yReq && yOk && yRes.wb;
         macError     <= next_macError;
         branchValid  <= branchReq;
         branchTarget <= 16'(branchPc + branchLit);
         holdActive   <= next_holdCount != '0;
         if (xrReq && xrOk && xrRes.mem)
            lastXEa <= xrRes.ea;
         if (yReq && yOk)
            lastYEa <= yEaWord;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   wire logic [15:0] xrStep = 16'(xrPtr + xrMod);

   sequence s_busReq;
      busReq && avsWaitrequest;
   endsequence
   sequence s_busAck;
      !avsWaitrequest ##1 avsWaitrequest;
   endsequence

   property p_bus_answer;
      s_busReq |=> s_busAck;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("bus answer not given after one wait cycle");

   property p_file_near;
      xrReq && xrMode == MODE_FILE && !xrMovFull && !xrMac
         |=> xrValid && xrAddr[15:FILE_ADDR_W] == '0 && xrImplicitW0;
   endproperty
   a_file_near: assert property (p_file_near)
      else $error("file address left the near space");

   property p_post_addr;
      xrReq && xrMode == MODE_POST && !xrMac
         |=> xrAddr == $past(xrPtr) && xrPtrWrite;
   endproperty
   a_post_addr: assert property (p_post_addr)
      else $error("post-modify address is not the old pointer");

   property p_pre_linear;
      xrReq && xrMode == MODE_PRE && !xrMac && !xrCirc
         |=> xrAddr == $past(xrStep) && xrPtrNew == xrAddr;
   endproperty
   a_pre_linear: assert property (p_pre_linear)
      else $error("pre-modify address differs from stepped pointer");

   property p_offset_nowb;
      xrReq && (xrMode == MODE_INDEXED || xrMode == MODE_LITOFF) |=> !xrPtrWrite;
   endproperty
   a_offset_nowb: assert property (p_offset_nowb)
      else $error("offset mode wrote the pointer back");

   property p_y_word;
      yValid |-> yAddr[0] == 1'b0 && yPtrNew[0] == 1'b0;
   endproperty
   a_y_word: assert property (p_y_word)
      else $error("y address has bit zero set");

   property p_y_reject;
      yReq && !yPtrOk |=> macError && !yValid;
   endproperty
   a_y_reject: assert property (p_y_reject)
      else $error("y request outside W10 and W11 accepted");

   property p_circ_inside;
      xrReq && xrMode == MODE_PRE && xrCirc && !xrMac && xStart <= xEnd
         && xrStep >= xStart && xrStep <= 16'(xEnd + xrMod)
         |=> xrAddr >= xStart && xrAddr <= xEnd;
   endproperty
   a_circ_inside: assert property (p_circ_inside)
      else $error("circular address left the buffer");

   sequence s_holdLoad;
      holdLoad && holdLit > HOLD_W'(2) && !wrHold;
   endsequence
   property p_hold_count;
      s_holdLoad |=> holdCount == $past(holdLit) && holdActive
         ##1 holdCount == HOLD_W'($past(holdCount) - 1'b1) || $past(holdLoad)
            || $past(wrHold);
   endproperty
   a_hold_count: assert property (p_hold_count)
      else $error("hold count did not load and count down");

endmodule // agu_address_unit

`default_nettype wire

//--- tb/agu_regfile_model.sv
/*
   agu_regfile_model: pointer registers that feed the address unit.
   assumes: one clock; bench loads pointers, unit writes pointers back.
*/
`default_nettype none
module agu_regfile_model
(
   input  wire logic        clk,
   input  wire logic        ldEn,
   input  wire logic [3:0]  ldSel,
   input  wire logic [15:0] ldVal,
   input  wire logic [3:0]  xrPtrSel,
   input  wire logic        xrPtrWrite,
   input  wire logic [15:0] xrPtrNew,
   input  wire logic [3:0]  yPtrSel,
   input  wire logic        yPtrWrite,
   input  wire logic [15:0] yPtrNew,
   output logic [15:0]      xrPtr,
   output logic [15:0]      yPtr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] w [16];
   // pointers hold any value the bench loads or the unit writes back
   assign xrPtr = w[xrPtrSel];
   assign yPtr  = w[yPtrSel];
   always_ff @(posedge clk)
   begin
      if (ldEn) w[ldSel] <= ldVal;
      if (xrPtrWrite) w[xrPtrSel] <= xrPtrNew;
      if (yPtrWrite) w[yPtrSel] <= yPtrNew;
   end
endmodule // agu_regfile_model
`default_nettype wire

//--- tb/test_agu_address_unit.sv
/*
   test_agu_address_unit: scoreboard bench for the address unit.
   assumes: agu_pkg and the pointer register model compiled first.
*/
`default_nettype none
module test_agu_address_unit;
   timeunit 1ns;
   timeprecision 1ps;
   import agu_pkg::*;
   logic clk = 0, rst_b = 0, avsRead = 0, avsWrite = 0, ldEn = 0, mac = 0, full = 0;
   logic xrReq = 0, xwReq = 0, yReq = 0, branchReq = 0;
   logic [3:0] sel = 0, ldSel = 0;
   logic [15:0] avsAddress = 0, mo = 0, offsetValue = 0, ldVal = 0, branchPc = 0, branchLit = 0;
   logic [31:0] avsWritedata = 0, avsReaddata, r;
   logic [15:0] xrPtr, yPtr, xrAddr, xrPtrNew, xrOperand, xwAddr, xwPtrNew, yAddr, yPtrNew;
   logic [15:0] branchTarget, q [$];
   logic avsWaitrequest, xrValid, xrPtrWrite, xrLitValid, xrImplicitW0, xwValid, xwPtrWrite;
   logic yValid, yPtrWrite, macError, branchValid, holdActive;
   agu_mode_type md = MODE_DIRECT;
   wire agu_mode_type xrMode = md, xwMode = md, yMode = md;
   wire logic [3:0] xrPtrSel = sel, xwPtrSel = sel, yPtrSel = sel, avsByteenable = 4'hf;
   wire logic [15:0] xrMod = mo, xwMod = mo, yMod = mo, xrLit = mo, xwLit = mo, xwPtr = xrPtr;
   wire logic xrMac = mac, xrMovFull = full, xwMovFull = full;
   agu_lit_type xrLitWidth = LIT_16;
   logic holdLoad = 1'b0;
   logic [13:0] holdLit = 14'h0000;
   logic [13:0] ix [6] = '{IDX_X_START, IDX_X_END, IDX_Y_START, IDX_Y_END, IDX_MODE_CTL, 14'h0050};
   logic [15:0] wv [6] = '{16'h0200, 16'h020f, 16'h0300, 16'h0307, 16'hf0a1, 16'h1234};
   logic [15:0] ev [6] = '{16'h0200, 16'h020f, 16'h0300, 16'h0307, 16'hc0a1, 16'h0000};
   int mismatches = 0, tests_run = 0, seed = 97, cyc = 0;

   agu_address_unit dut (.*);
   agu_regfile_model model (.*);

   initial forever #5 clk = ~clk;

   task automatic chk(input string n, input logic [15:0] g);
      logic [15:0] e;
      e = 16'hxxxx;
      if (q.size() != 0) e = q.pop_front();
      tests_run++;
      if ($isunknown(e) || e !== g)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic tally_and_finish;
      if (q.size() != 0) mismatches++;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [13:0] idx, input logic [15:0] d, e);
      @(posedge clk);
      avsAddress <= {idx, 2'b00};
      avsWritedata <= {16'h0000, d};
      avsWrite <= wr;
      avsRead <= !wr;
      if (!wr) q.push_back(e);
      do @(posedge clk); while (avsWaitrequest !== 1'b0);
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
   endtask

   task automatic ld(input logic [3:0] s, input logic [15:0] v);
      @(posedge clk);
      ldEn <= 1'b1;
      ldSel <= s;
      ldVal <= v;
      @(posedge clk);
      ldEn <= 1'b0;
   endtask

   // u: 0 x read, 1 y read, 2 x read dual operand, 3 x write
   task automatic rq(input int u, input agu_mode_type m, input logic [3:0] s,
                     input logic [15:0] d, a, p, input logic w);
      @(posedge clk);
      md <= m;
      sel <= s;
      mo <= d;
      offsetValue <= d;
      mac <= (u == 2);
      xrReq <= (u == 0 || u == 2);
      yReq <= (u == 1);
      xwReq <= (u == 3);
      q.push_back(a);
      if (w) q.push_back(p);
      @(posedge clk);
      xrReq <= 1'b0;
      yReq <= 1'b0;
      xwReq <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   always @(negedge clk)
   begin
      if (avsRead === 1'b1 && avsWaitrequest === 1'b0)
         chk("readdata", avsReaddata[15:0]);
      if (xrValid === 1'b1) chk("xrAddr", xrAddr);
      if (xrPtrWrite === 1'b1) chk("xrPtrNew", xrPtrNew);
      if (xrImplicitW0 === 1'b1) chk("xrImplicitW0", 16'h0001);
      if (xrLitValid === 1'b1) chk("xrOperand", xrOperand);
      if (xwValid === 1'b1) chk("xwAddr", xwAddr);
      if (xwPtrWrite === 1'b1) chk("xwPtrNew", xwPtrNew);
      if (yValid === 1'b1) chk("yAddr", yAddr);
      if (yPtrWrite === 1'b1) chk("yPtrNew", yPtrNew);
      if (macError === 1'b1) chk("macError", 16'h0e00);
      if (branchValid === 1'b1) chk("branchTarget", branchTarget);
      if (holdActive === 1'b1) chk("holdActive", 16'h0001);
   end

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 1000)
      begin
         mismatches++;
         tally_and_finish;
      end
   end

   initial
   begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      bus(1'b0, IDX_X_END, 16'h0000, 16'h0001);
      // circular pointers W1 and W10, never W14 or W15
      for (int i = 0; i < 6; i++) bus(1'b1, ix[i], wv[i], 16'h0000);
      for (int i = 0; i < 6; i++) bus(1'b0, ix[i], 16'h0000, ev[i]);
      $display("test registers done");
      ld(4'h2, 16'h0100);
      rq(0, MODE_POST, 4'h2, 16'h0002, 16'h0100, 16'h0102, 1'b1);
      rq(0, MODE_PRE, 4'h2, 16'hfffe, 16'h0100, 16'h0100, 1'b1);
      rq(0, MODE_IND, 4'h2, 16'h0000, 16'h0100, 16'h0000, 1'b0);
      rq(0, MODE_INDEXED, 4'h2, 16'h0010, 16'h0110, 16'h0000, 1'b0);
      rq(3, MODE_LITOFF, 4'h2, 16'h0020, 16'h0120, 16'h0000, 1'b0);
      rq(0, MODE_FILE, 4'h0, 16'hffff, 16'h1fff, 16'h0001, 1'b1);
      full <= 1'b1;
      rq(0, MODE_FILE, 4'h0, 16'hffff, 16'hffff, 16'h0001, 1'b1);
      full <= 1'b0;
      xrLitWidth <= LIT_5;
      rq(0, MODE_LITERAL, 4'h0, 16'hffff, 16'h001f, 16'h0000, 1'b0);
      xrLitWidth <= LIT_8;
      rq(0, MODE_LITERAL, 4'h0, 16'hffff, 16'h00ff, 16'h0000, 1'b0);
      xrLitWidth <= LIT_16;
      rq(0, MODE_LITERAL, 4'h0, 16'h8421, 16'h8421, 16'h0000, 1'b0);
      $display("test linear done");
      ld(4'h1, 16'h020e);
      rq(0, MODE_POST, 4'h1, 16'h0004, 16'h020e, 16'h0202, 1'b1);
      rq(0, MODE_LITOFF, 4'h1, 16'h0010, 16'h0202, 16'h0000, 1'b0);
      rq(3, MODE_PRE, 4'h1, 16'hfffc, 16'h020e, 16'h020e, 1'b1);
      rq(0, MODE_PRE, 4'h1, 16'h000e, 16'h0200, 16'h0200, 1'b1);
      ld(4'ha, 16'h0306);
      rq(1, MODE_POST, 4'ha, 16'h0002, 16'h0306, 16'h0300, 1'b1);
      $display("test circular done");
      rq(1, MODE_POST, 4'h8, 16'h0002, 16'h0e00, 16'h0000, 1'b0);
      rq(1, MODE_POST, 4'ha, 16'h0008, 16'h0e00, 16'h0000, 1'b0);
      rq(2, MODE_IND, 4'ha, 16'h0000, 16'h0e00, 16'h0000, 1'b0);
      ld(4'h9, 16'h0180);
      rq(2, MODE_INDEXED, 4'h9, 16'h0004, 16'h0184, 16'h0000, 1'b0);
      $display("test dual operand done");
      for (int i = 0; i < 4; i++)
      begin
         r = $random(seed);
         ld(4'h3, r[15:0]);
         rq(0, MODE_IND, 4'h3, 16'h0000, r[15:0], 16'h0000, 1'b0);
         @(posedge clk);
         branchPc <= r[15:0];
         branchLit <= r[31:16];
         branchReq <= 1'b1;
         q.push_back(r[15:0] + r[31:16]);
         @(posedge clk);
         branchReq <= 1'b0;
      end
      repeat (3) @(posedge clk);
      $display("test random done");
      @(posedge clk);
      holdLit <= 14'h0003;
      holdLoad <= 1'b1;
      repeat (3) q.push_back(16'h0001);
      @(posedge clk);
      holdLoad <= 1'b0;
      repeat (5) @(posedge clk);
      $display("test hold done");
      tally_and_finish;
   end
endmodule // test_agu_address_unit
`default_nettype wire
